/* File: include/mrl_pkg.sv */
// Constants, codes and carrier types of the motor ramp, limit and alarm controller
package mrl_pkg;
  // ==========================================================================
  // Clock and time
  localparam int unsigned CLK_NS       = 25;
  localparam int unsigned DS_NS        = 100_000_000;           // One ramp-time unit, 0.1 s
  localparam int unsigned CYC_PER_DS   = DS_NS / CLK_NS;
  localparam int unsigned LOCK_SHOW_MS = 1000;
  localparam int unsigned LOCK_SHOW_CYC = LOCK_SHOW_MS * (1_000_000 / CLK_NS);
  localparam int unsigned ARST_HOLD_MS = 10;
  localparam int unsigned ARST_HOLD_CYC = ARST_HOLD_MS * (1_000_000 / CLK_NS);
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_RAMP   = 8'h08;
  localparam logic [7:0] OFS_POT    = 8'h0C;
  localparam logic [7:0] OFS_EDIT   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Field positions
  localparam int CTRL_DIGITAL = 0;
  localparam int CTRL_HOLD    = 1;
  localparam int CTRL_LOCK    = 2;
  localparam int HI_LSB       = 16;
  localparam int DEC_LSB      = 8;
  localparam int EDIT_IDX_LSB = 16;
  localparam int ST_ACTIVE    = 8;
  localparam int ST_LOCKIND   = 9;
  localparam int ST_WARN_LSB  = 10;
  localparam int ST_SPD_LSB   = 16;
  // ==========================================================================
  // Speeds in r/min, ramp times in 0.1 s
  localparam logic [12:0] RATED_RPM    = 13'd3000;
  localparam logic [12:0] LIM_LO_RST   = 13'd50;
  localparam logic [12:0] LIM_HI_RST   = 13'd4000;
  localparam logic [12:0] DATA_SPD_RST = 13'd50;
  localparam logic [7:0]  T_MIN        = 8'd1;
  localparam logic [7:0]  T_MAX        = 8'd150;
  localparam logic [7:0]  T_HONOUR     = 8'd5;
  localparam logic [7:0]  POT_T_RST    = 8'd1;
  localparam logic [7:0]  DIG_T_RST    = 8'd5;
  // Supply thresholds and hold torque cap in percent of rated; over-temperature warning margin
  localparam int unsigned OV_PCT      = 120;
  localparam int unsigned UV_PCT      = 60;
  localparam int unsigned OV_WARN_PCT = 115;
  localparam int unsigned UV_WARN_PCT = 65;
  localparam int unsigned HOLD_PCT    = 50;
  localparam logic [7:0]  OT_MARGIN   = 8'd10;
  // ==========================================================================
  // Alarm codes
  localparam logic [7:0] OVERCURRENT_CODE   = 8'h20;
  localparam logic [7:0] OVERHEAT_CODE      = 8'h21;
  localparam logic [7:0] OVERVOLTAGE_CODE   = 8'h22;
  localparam logic [7:0] UNDERVOLTAGE_CODE  = 8'h25;
  localparam logic [7:0] NVDATA_ERR_CODE    = 8'h41;
  localparam logic [7:0] EXTERNAL_HALT_CODE = 8'h5E;
  localparam logic [7:0] NO_ALARM_CODE      = 8'h00;

  typedef enum logic [1:0] {
    AL_NONE    = 2'b00,
    AL_HALTING = 2'b01,
    AL_LATCHED = 2'b11
  } mrl_al_state_t;

  // Pin inputs from outside the clock domain
  typedef struct packed {
    logic       forward_run_input;
    logic       alarm_reset_in;
    logic       ext_ok;
    logic       overcurrent;
    logic       nvdata_err;
    logic       motor_still;
    logic [1:0] data_sel;
  } mrl_pins_t;

  // Idle pin levels; external stop is active low, so a zero reset would fake a halt
  localparam mrl_pins_t PINS_IDLE = 8'h24;

  // Warning flags
  typedef struct packed {
    logic over_temp;
    logic under_volt;
    logic over_volt;
  } mrl_warn_t;
endpackage

/* File: rtl/mrl_ctrl.sv */
// Ramp generator, edit lock, speed limits, standstill hold and alarms of a motor driver
`timescale 1ns/1ps
module mrl_ctrl
  import mrl_pkg::*;
#(
  parameter int unsigned  LOCK_SHOW  = LOCK_SHOW_CYC,
  parameter int unsigned  ARST_HOLD  = ARST_HOLD_CYC,
  parameter logic [9:0]   RATED_VSUP = 10'd500,
  parameter logic [7:0]   OT_LEVEL   = 8'd200,
  parameter logic [11:0]  HOLD_RATED = 12'd1000,
  parameter logic [3:0]   HOLD_GAIN  = 4'd4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire mrl_pins_t   pins,
  input  wire logic [9:0]  vsup,
  input  wire logic [7:0]  temp,
  input  wire logic signed [11:0] shaft_dev,
  output logic [12:0]      speed_cmd,
  output logic             drive_en,
  output logic             brake,
  output logic signed [11:0] hold_torque,
  output logic [7:0]       alarm_code,
  output logic             edit_locked_indication,
  output mrl_warn_t        warn
);
  localparam logic [9:0]  OV_LVL = 10'((32'(RATED_VSUP) * OV_PCT) / 100);
  localparam logic [9:0]  UV_LVL = 10'((32'(RATED_VSUP) * UV_PCT) / 100);
  localparam logic [9:0]  OV_WRN = 10'((32'(RATED_VSUP) * OV_WARN_PCT) / 100);
  localparam logic [9:0]  UV_WRN = 10'((32'(RATED_VSUP) * UV_WARN_PCT) / 100);
  localparam logic signed [11:0] HOLD_MAX = 12'((32'(HOLD_RATED) * HOLD_PCT) / 100);

  function automatic logic [12:0] clamp_spd(input logic [12:0] v, input logic [12:0] lo,
                                            input logic [12:0] hi);
    clamp_spd = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  function automatic logic [7:0] clamp_t(input logic [7:0] v);
    clamp_t = (v > T_MAX) ? T_MAX : ((v < T_MIN) ? T_MIN : v);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  mrl_pins_t pins_m_q;
  mrl_pins_t pins_s_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_m_q <= PINS_IDLE;
      pins_s_q <= PINS_IDLE;
    end else begin
      pins_m_q <= pins;
      pins_s_q <= pins_m_q;
    end
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic        ph_wr_q;
  logic [7:0]  ph_ofs_q;
  logic [31:0] hrdata_q;
  logic        acc_take;
  assign acc_take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q  <= 1'b0;
      ph_ofs_q <= 8'h00;
    end else begin
      ph_wr_q  <= acc_take && hwrite && (haddr[31:8] == 24'h0);
      ph_ofs_q <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ==========================================================================
  // Settings
  logic        digital_q;
  logic        hold_sel_q;
  logic        lock_q;
  logic [12:0] lim_lo_q;
  logic [12:0] lim_hi_q;
  logic [7:0]  dig_acc_q;
  logic [7:0]  dig_dec_q;
  logic [7:0]  pot_acc_q;
  logic [7:0]  pot_dec_q;
  logic [12:0] data_spd_q [4];
  logic        wr_ctrl, wr_lim, wr_ramp, wr_edit, wr_pot;
  logic        setting_try;
  logic [12:0] new_lo, new_hi, edit_spd;
  assign wr_ctrl  = ph_wr_q && ph_ofs_q == OFS_CTRL;
  assign wr_lim   = ph_wr_q && ph_ofs_q == OFS_LIMIT;
  assign wr_ramp  = ph_wr_q && ph_ofs_q == OFS_RAMP;
  assign wr_pot   = ph_wr_q && ph_ofs_q == OFS_POT;
  assign wr_edit  = ph_wr_q && ph_ofs_q == OFS_EDIT;
  assign new_lo   = hwdata[12:0];
  assign new_hi   = hwdata[HI_LSB +: 13];
  assign edit_spd = hwdata[12:0];
  // Any write that would change a setting; the lock bit itself is never blocked
  assign setting_try = wr_lim || wr_ramp || wr_edit ||
                       (wr_ctrl && ({hwdata[CTRL_HOLD], hwdata[CTRL_DIGITAL]} !=
                                    {hold_sel_q, digital_q}));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b0;
    end else if (wr_ctrl) begin
      lock_q <= hwdata[CTRL_LOCK];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      digital_q  <= 1'b0;
      hold_sel_q <= 1'b0;
      lim_lo_q   <= LIM_LO_RST;
      lim_hi_q   <= LIM_HI_RST;
      dig_acc_q  <= DIG_T_RST;
      dig_dec_q  <= DIG_T_RST;
    end else if (!lock_q) begin
      if (wr_ctrl) begin
        digital_q  <= hwdata[CTRL_DIGITAL];
        hold_sel_q <= hwdata[CTRL_HOLD];
      end
      // Bounds may only narrow the shipped range
      if (wr_lim && new_lo >= LIM_LO_RST && new_hi <= LIM_HI_RST && new_lo <= new_hi) begin
        lim_lo_q <= new_lo;
        lim_hi_q <= new_hi;
      end
      if (wr_ramp) begin
        dig_acc_q <= clamp_t(hwdata[7:0]);
        dig_dec_q <= clamp_t(hwdata[DEC_LSB +: 8]);
      end
    end
  end

  // Potentiometer readings come from the analog front end and are not lockable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pot_acc_q <= POT_T_RST;
      pot_dec_q <= POT_T_RST;
    end else if (wr_pot) begin
      pot_acc_q <= clamp_t(hwdata[7:0]);
      pot_dec_q <= clamp_t(hwdata[DEC_LSB +: 8]);
    end
  end

  // Operation data; stored entries follow any change of the bounds
  for (genvar i = 0; i < 4; i++) begin : g_data
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        data_spd_q[i] <= DATA_SPD_RST;
      end else if (wr_edit && !lock_q && hwdata[EDIT_IDX_LSB +: 2] == 2'(i) &&
                   edit_spd >= lim_lo_q && edit_spd <= lim_hi_q) begin
        data_spd_q[i] <= edit_spd;
      end else begin
        data_spd_q[i] <= clamp_spd(data_spd_q[i], lim_lo_q, lim_hi_q);
      end
    end
  end

  // ==========================================================================
  // Lock indication
  logic [31:0] lock_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_q <= 32'h0;
    end else if (lock_q && setting_try) begin
      lock_cnt_q <= LOCK_SHOW;
    end else if (lock_cnt_q != 32'h0) begin
      lock_cnt_q <= lock_cnt_q - 32'h1;
    end
  end

  // ==========================================================================
  // Protection
  mrl_al_state_t al_state_q;
  logic [7:0]    al_code_q;
  logic [7:0]    cause_code;
  logic          ov_hit, uv_hit, ot_hit, run_req, resettable;
  logic [31:0]   arst_cnt_q;
  logic          arst_prev_q;
  logic          arst_fire;
  assign ov_hit  = vsup > OV_LVL;
  assign uv_hit  = vsup < UV_LVL;
  assign ot_hit  = temp > OT_LEVEL;
  assign run_req = pins_s_q.forward_run_input;
  always_comb begin
    if (pins_s_q.overcurrent)      cause_code = OVERCURRENT_CODE;
    else if (pins_s_q.nvdata_err)  cause_code = NVDATA_ERR_CODE;
    else if (!pins_s_q.ext_ok)     cause_code = EXTERNAL_HALT_CODE;
    else if (ov_hit)               cause_code = OVERVOLTAGE_CODE;
    else if (uv_hit)               cause_code = UNDERVOLTAGE_CODE;
    else if (ot_hit)               cause_code = OVERHEAT_CODE;
    else                           cause_code = NO_ALARM_CODE;
  end
  // Power cycle is the only way out for these two
  assign resettable = al_code_q != OVERCURRENT_CODE && al_code_q != NVDATA_ERR_CODE;

  // Reset input must be held long enough with the run command off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arst_cnt_q  <= 32'h0;
      arst_prev_q <= 1'b0;
    end else begin
      arst_prev_q <= pins_s_q.alarm_reset_in;
      if (!pins_s_q.alarm_reset_in || run_req) begin
        arst_cnt_q <= (pins_s_q.alarm_reset_in || !arst_prev_q) ? 32'h0 : arst_cnt_q;
      end else if (arst_cnt_q < ARST_HOLD) begin
        arst_cnt_q <= arst_cnt_q + 32'h1;
      end
    end
  end
  assign arst_fire = arst_prev_q && !pins_s_q.alarm_reset_in && !run_req &&
                     arst_cnt_q >= ARST_HOLD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      al_state_q <= AL_NONE;
      al_code_q  <= NO_ALARM_CODE;
    end else begin
      case (al_state_q)
        AL_NONE: begin
          if (cause_code != NO_ALARM_CODE) begin
            al_code_q  <= cause_code;
            al_state_q <= (cause_code == EXTERNAL_HALT_CODE) ? AL_HALTING : AL_LATCHED;
          end
        end
        AL_HALTING: begin
          if (pins_s_q.motor_still) begin
            al_state_q <= AL_LATCHED;
          end
        end
        AL_LATCHED: begin
          if (arst_fire && resettable) begin
            al_state_q <= AL_NONE;
            al_code_q  <= NO_ALARM_CODE;
          end
        end
        default: begin
          al_state_q <= AL_LATCHED;
        end
      endcase
    end
  end

  // Early warnings sit inside the alarm thresholds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn <= '0;
    end else begin
      warn.over_volt  <= vsup > OV_WRN;
      warn.under_volt <= vsup < UV_WRN;
      warn.over_temp  <= temp > (OT_LEVEL - OT_MARGIN);
    end
  end

  // ==========================================================================
  // Ramp generator
  logic [12:0] set_spd, target, span;
  logic [7:0]  t_sel, t_eff;
  logic [31:0] t_cyc, ramp_acc_q, acc_sum;
  logic        going_up;
  logic        alarm_on;
  assign alarm_on = al_state_q != AL_NONE;
  assign set_spd  = data_spd_q[pins_s_q.data_sel];
  assign target   = (run_req && !alarm_on) ? set_spd : 13'd0;
  assign going_up = target > speed_cmd;
  always_comb begin
    if (digital_q) begin
      t_sel = going_up ? dig_acc_q : dig_dec_q;
      span  = set_spd;
    end else begin
      t_sel = going_up ? pot_acc_q : pot_dec_q;
      span  = RATED_RPM;
    end
  end
  assign t_eff   = (t_sel < T_HONOUR) ? T_HONOUR : t_sel;
  assign t_cyc   = 32'(t_eff) * CYC_PER_DS;
  assign acc_sum = ramp_acc_q + 32'(span);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_cmd  <= 13'd0;
      ramp_acc_q <= 32'h0;
    end else if (alarm_on) begin
      speed_cmd  <= 13'd0;
      ramp_acc_q <= 32'h0;
    end else if (target == speed_cmd) begin
      ramp_acc_q <= 32'h0;
    end else if (acc_sum >= t_cyc) begin
      ramp_acc_q <= acc_sum - t_cyc;
      speed_cmd  <= going_up ? speed_cmd + 13'd1 : speed_cmd - 13'd1;
    end else begin
      ramp_acc_q <= acc_sum;
    end
  end

  // ==========================================================================
  // Power stage, hold torque and display outputs
  logic signed [15:0] hold_raw;
  logic               hold_on;
  assign hold_raw = 16'(shaft_dev) * $signed({12'h0, HOLD_GAIN});
  assign hold_on  = hold_sel_q && !alarm_on && !run_req && speed_cmd == 13'd0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_en               <= 1'b0;
      brake                  <= 1'b0;
      hold_torque            <= 12'sd0;
      alarm_code             <= NO_ALARM_CODE;
      edit_locked_indication <= 1'b0;
    end else begin
      drive_en               <= !alarm_on && (run_req || speed_cmd != 13'd0 || hold_on);
      brake                  <= al_state_q == AL_HALTING;
      alarm_code             <= al_code_q;
      edit_locked_indication <= lock_cnt_q != 32'h0;
      if (!hold_on) begin
        hold_torque <= 12'sd0;
      end else if (hold_raw > 16'(HOLD_MAX)) begin
        hold_torque <= HOLD_MAX;
      end else if (hold_raw < -16'(HOLD_MAX)) begin
        hold_torque <= -HOLD_MAX;
      end else begin
        hold_torque <= 12'(hold_raw);
      end
    end
  end

  // Read data is sampled in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
    end else if (acc_take && !hwrite) begin
      case (haddr[31:0])
        32'(OFS_CTRL):   hrdata_q <= {29'h0, lock_q, hold_sel_q, digital_q};
        32'(OFS_LIMIT):  hrdata_q <= {3'h0, lim_hi_q, 3'h0, lim_lo_q};
        32'(OFS_RAMP):   hrdata_q <= {16'h0, dig_dec_q, dig_acc_q};
        32'(OFS_POT):    hrdata_q <= {16'h0, pot_dec_q, pot_acc_q};
        32'(OFS_EDIT):   hrdata_q <= {14'h0, pins_s_q.data_sel, 3'h0, set_spd};
        32'(OFS_STATUS): hrdata_q <= {3'h0, speed_cmd, 3'h0, warn, edit_locked_indication,
                                      alarm_on, alarm_code};
        default:         hrdata_q <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_lock_show: assert property (lock_q && setting_try |=> ##1 edit_locked_indication)
    else $error("lock indication not shown");
  a_lock_keep: assert property (lock_q && wr_lim |=> $stable(lim_lo_q) && $stable(lim_hi_q))
    else $error("locked bound changed");
  a_spd_bound: assert property (##1 set_spd <= lim_hi_q && set_spd >= lim_lo_q || $changed(lim_lo_q) || $changed(lim_hi_q) || $past(wr_edit))
    else $error("stored speed out of bounds");
  a_alarm_coast: assert property ($rose(alarm_on) |=> speed_cmd == 13'd0 ##0 !drive_en ##0 hold_torque == 12'sd0)
    else $error("drive not removed on alarm");
  a_halt_brake: assert property (al_state_q == AL_HALTING |=> brake || al_state_q == AL_LATCHED)
    else $error("halt without brake");
  a_ov_trip: assert property (al_state_q == AL_NONE && vsup > OV_LVL && pins_s_q.ext_ok && !pins_s_q.overcurrent && !pins_s_q.nvdata_err |=> al_code_q == OVERVOLTAGE_CODE)
    else $error("overvoltage missed");
  a_uv_trip: assert property (al_state_q == AL_NONE && cause_code == UNDERVOLTAGE_CODE |=> ##1 alarm_code == UNDERVOLTAGE_CODE)
    else $error("undervoltage missed");
  a_oc_sticky: assert property (al_code_q == OVERCURRENT_CODE |=> al_code_q == OVERCURRENT_CODE)
    else $error("overcurrent alarm cleared");
  a_run_noreset: assert property (run_req && al_state_q == AL_LATCHED |=> al_state_q == AL_LATCHED)
    else $error("reset taken while running");
  a_hold_cap: assert property (hold_torque <= HOLD_MAX && hold_torque >= -HOLD_MAX)
    else $error("hold torque above limit");
  a_ramp_step: assert property (!alarm_on ##1 !alarm_on |-> speed_cmd - $past(speed_cmd) <= 13'd1 || $past(speed_cmd) - speed_cmd <= 13'd1)
    else $error("ramp stepped more than one");
endmodule

/* File: tb/mrl_ctrl_tb_top.sv */
// Self-checking bench of the ramp, limit and alarm controller
`timescale 1ns/1ps
module mrl_ctrl_tb_top;
  import mrl_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0]  htrans = 2'h0, dsel = 2'h0;
  logic        hreadyout, hresp, drive_en, brake, eli, still;
  logic        run = 1'b0, arst = 1'b0, ext_ok = 1'b1, oc = 1'b0, nv = 1'b0;
  logic [9:0]  vsup = 10'd500;
  logic [7:0]  temp = 8'd25, alarm_code;
  logic [12:0] speed_cmd;
  logic signed [11:0] dev_set = 12'sh0, shaft_dev, hold_torque;
  mrl_warn_t   warn;
  int          bad_count = 0, n_checks = 0, s, d;
  always #12.5 hclk = ~hclk;
  mrl_ctrl #(.LOCK_SHOW(20), .ARST_HOLD(8)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pins({run, arst, ext_ok, oc, nv, still, dsel}), .vsup(vsup),
    .temp(temp), .shaft_dev(shaft_dev), .speed_cmd(speed_cmd), .drive_en(drive_en),
    .brake(brake), .hold_torque(hold_torque), .alarm_code(alarm_code),
    .edit_locked_indication(eli), .warn(warn));
  mrl_motor_model motor (.hclk(hclk), .speed_cmd(speed_cmd), .drive_en(drive_en),
    .brake(brake), .dev_set(dev_set), .motor_still(still), .shaft_dev(shaft_dev));
  // ==========================================================================
  // Tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dw);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    wait_rdy();
    htrans <= 2'h0; hwdata <= dw;
    wait_rdy();
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rv);
    chk("hresp", 0, hresp);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic wait_code(input logic [7:0] e);
    int k;
    k = 0;
    while (alarm_code !== e && k < 40) begin
      @(posedge hclk);
      k++;
    end
    chk("alarm_code", e, alarm_code);
  endtask
  // Reset pulse longer than the hold count, code must survive the rising edge
  task automatic clr(input logic [7:0] e, input logic [7:0] after);
    arst <= 1'b1;
    repeat (12) @(posedge hclk);
    chk("code at rise", e, alarm_code);
    arst <= 1'b0;
    // Longer than sync plus clear latency, so an ignored reset is seen
    repeat (6) @(posedge hclk);
    wait_code(after);
  endtask
  task automatic alarm_case(input logic [9:0] v, input logic [7:0] t, input logic x,
                            input logic [7:0] code);
    vsup <= v; temp <= t; ext_ok <= x;
    wait_code(code);
    chk("drive_en", 0, drive_en);
    chk("brake", 32'(code == EXTERNAL_HALT_CODE), brake);
    chk("warn", {t > 8'd190, v < 10'd325, v > 10'd575}, warn);
    vsup <= 10'd500; temp <= 8'd25; ext_ok <= 1'b1;
    repeat (4) @(posedge hclk);
    clr(code, NO_ALARM_CODE);
    $display("alarm test %h done", code);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    finish_test();
  end
  initial begin
    s = $urandom(73);
    rst();
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_LIMIT, {3'h0, LIM_HI_RST, 3'h0, LIM_LO_RST}, "limit");
    rd(OFS_RAMP, {16'h0, DIG_T_RST, DIG_T_RST}, "ramp");
    rd(8'h40, 32'h0, "unmapped");
    ahb(1'b1, OFS_LIMIT, {3'h0, 13'd4001, 3'h0, 13'd100});
    rd(OFS_LIMIT, {3'h0, LIM_HI_RST, 3'h0, LIM_LO_RST}, "limit wide");
    ahb(1'b1, OFS_LIMIT, {3'h0, 13'd3000, 3'h0, 13'd100});
    // Stored speeds follow new bounds one cycle later
    @(posedge hclk);
    rd(OFS_EDIT, 32'd100, "clamp lo");
    ahb(1'b1, OFS_EDIT, 32'd3500);
    rd(OFS_EDIT, 32'd100, "refuse hi");
    s = 300 + $urandom_range(2700);
    ahb(1'b1, OFS_EDIT, s);
    rd(OFS_EDIT, s, "edit");
    ahb(1'b1, OFS_LIMIT, {3'h0, 13'd200, 3'h0, 13'd100});
    @(posedge hclk);
    rd(OFS_EDIT, 32'd200, "clamp hi");
    $display("limit test done");
    ahb(1'b1, OFS_CTRL, 32'h4);
    ahb(1'b1, OFS_RAMP, 32'h141E);
    repeat (3) @(posedge hclk);
    chk("lock ind", 1, eli);
    rd(OFS_RAMP, {16'h0, DIG_T_RST, DIG_T_RST}, "locked ramp");
    repeat (25) @(posedge hclk);
    chk("lock ind off", 0, eli);
    // Unlock first: a write that unlocks still has its setting bits blocked
    ahb(1'b1, OFS_CTRL, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h2);
    rd(OFS_CTRL, 32'h2, "unlock");
    $display("lock test done");
    d = $urandom_range(200) - 100;
    dev_set <= 12'(d);
    repeat (4) @(posedge hclk);
    chk("hold", 12'(d * 4), hold_torque);
    ahb(1'b1, OFS_CTRL, 32'h0);
    run <= 1'b1;
    // One r/min step needs ceil(20e6/3000) = 6667 cycles
    repeat (6000) @(posedge hclk);
    chk("ramp early", 0, speed_cmd);
    repeat (1000) @(posedge hclk);
    chk("ramp step", 1, speed_cmd);
    run <= 1'b0;
    $display("ramp test done");
    vsup <= 10'd580;
    repeat (4) @(posedge hclk);
    chk("warn ov", 3'b001, warn);
    chk("no alarm", 0, alarm_code);
    vsup <= 10'd620;
    wait_code(OVERVOLTAGE_CODE);
    vsup <= 10'd500;
    arst <= 1'b1;
    repeat (3) @(posedge hclk);
    arst <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("short reset", OVERVOLTAGE_CODE, alarm_code);
    run <= 1'b1;
    clr(OVERVOLTAGE_CODE, OVERVOLTAGE_CODE);
    run <= 1'b0;
    clr(OVERVOLTAGE_CODE, NO_ALARM_CODE);
    alarm_case(10'd250, 8'd25, 1'b1, UNDERVOLTAGE_CODE);
    alarm_case(10'd500, 8'd210, 1'b1, OVERHEAT_CODE);
    alarm_case(10'd500, 8'd25, 1'b0, EXTERNAL_HALT_CODE);
    oc <= 1'b1;
    wait_code(OVERCURRENT_CODE);
    oc <= 1'b0;
    clr(OVERCURRENT_CODE, OVERCURRENT_CODE);
    rst();
    chk("power reset", 0, alarm_code);
    $display("alarm test done");
    ahb(1'b1, OFS_EDIT, 32'd4000);
    ahb(1'b1, OFS_CTRL, 32'h1);
    run <= 1'b1;
    // Digital 0.5 s to reach 4000 r/min: one step per 5000 cycles
    repeat (4900) @(posedge hclk);
    chk("digital early", 0, speed_cmd);
    repeat (200) @(posedge hclk);
    chk("digital step", 1, speed_cmd);
    run <= 1'b0;
    $display("digital ramp test done");
    finish_test();
  end
endmodule

/* File: tb/mrl_motor_model.sv */
// Motor and shaft sensor model for the controller bench
`timescale 1ns/1ps
module mrl_motor_model (
  input  wire logic               hclk,
  input  wire logic [12:0]        speed_cmd,
  input  wire logic               drive_en,
  input  wire logic               brake,
  input  wire logic signed [11:0] dev_set,
  output logic                    motor_still,
  output logic signed [11:0]      shaft_dev
);
  logic [12:0] spd_q = 13'h0;
  // Shaft spins down over cycles, so still never shows early
  always_ff @(posedge hclk) begin
    spd_q <= (drive_en && !brake) ? speed_cmd : (spd_q >> 1);
  end
  assign motor_still = (spd_q == 13'h0);
  assign shaft_dev   = dev_set;
endmodule
